// [tcp_checker.sv]
// Purpose: horizontal code and vertical parity checker for punched tape input
// Assumes: reader gives one synchronous character strobe per character
// Notes: execution of a block is requested only when the block proved clean
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// - bad code halts reading after next character
// - horizontal error finishes prior block, alarm 001
// - erroneous block is discarded, never executed
// - alarm holds until reset clears it
// - latch bad character position in binary
// - latch bad character hole bits
// - odd block count gives alarm 002
// - parity error stops after faulty block end
// - operator switch enables vertical parity check
module tcp_checker (
  input wire logic clock, // 50 MHz system clock
  input wire logic reset_n, // asynchronous active-low reset
  input wire logic char_valid, // one-cycle strobe: character present
  input wire logic [7:0] char_holes, // hole pattern of character
  input wire logic char_in_zone, // character in significant zone
  output logic read_enable, // reader may advance the tape
  input wire logic block_busy, // preceding block still executing
  output logic block_execute, // pulse: block read is clean, run it
  output logic block_discard, // pulse: block read is faulty, drop it
  output logic [9:0] alarm_number, // number shown on indicator
  output logic horizontal_code_alarm, // horizontal code alarm level
  output logic vertical_parity_alarm, // vertical parity alarm level
  output logic alarm_lamp, // any tape alarm active
  input wire logic [11:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_write, // write strobe
  input wire logic reg_read, // read strobe
  output logic [31:0] reg_rdata // read data, cycle after strobe
);
  ////////////////////////////////////////////////////////////////////////////
  // code table lookup
  logic code_ok;
  logic code_eob;
  tcp_code_table u_table (
    .holes(char_holes),
    .in_zone(char_in_zone),
    .valid(code_ok),
    .is_eob(code_eob)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  tcp_pkg::tcp_state_t state_q;
  tcp_pkg::tcp_state_t state_d;
  logic [7:0] count_q; // characters since last end of block
  logic parity_q; // odd count so far in block
  logic halt_pend_q; // bad code seen, stop after next char
  logic [7:0] ctrl_q;
  logic [7:0] bad_pos_q;
  logic [7:0] bad_holes_q;
  logic h_alarm_q;
  logic v_alarm_q;
  logic exec_q;
  logic discard_q;
  logic block_bad_q; // horizontal error inside current block
  logic [31:0] rdata_q;

  wire vcheck_on = ctrl_q[tcp_pkg::ctrl_vcheck_bit];
  wire any_alarm = h_alarm_q | v_alarm_q;
  wire bad_char = char_valid && !code_ok && !any_alarm;
  // the end-of-block itself closes the count, so odd counts include it
  wire odd_block = char_valid && code_eob && (parity_q ^ 1'b1) && vcheck_on;

  ////////////////////////////////////////////////////////////////////////////
  // position counter; wrap is accepted, blocks are far shorter than 256
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= tcp_pkg::count_reset_value;
      parity_q <= 1'b0;
    end else if (char_valid && code_eob) begin
      count_q <= tcp_pkg::count_reset_value;
      parity_q <= 1'b0;
    end else if (char_valid) begin
      count_q <= count_q + 8'h01;
      parity_q <= ~parity_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: read, wait for prior block, then stop on alarm
  always_comb begin
    state_d = state_q;
    case (state_q)
      tcp_pkg::tcp_idle_s: begin
        state_d = tcp_pkg::tcp_read_s;
      end
      tcp_pkg::tcp_read_s: begin
        if (halt_pend_q && char_valid) begin
          state_d = tcp_pkg::tcp_drain_s;
        end else if (odd_block && !block_bad_q) begin
          state_d = tcp_pkg::tcp_drain_s;
        end
      end
      tcp_pkg::tcp_drain_s: begin
        if (!block_busy) begin
          state_d = tcp_pkg::tcp_stop_s;
        end
      end
      tcp_pkg::tcp_stop_s: begin
        state_d = tcp_pkg::tcp_stop_s;
      end
      default: begin
        state_d = tcp_pkg::tcp_idle_s;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= tcp_pkg::tcp_idle_s;
    end else begin
      state_q <= state_d;
    end
  end

  // reader runs only while reading and no stop is due
  // a pending halt drops it at once so only the character after the bad one is read
  assign read_enable = (state_q == tcp_pkg::tcp_read_s) && !halt_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // horizontal error capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      halt_pend_q <= 1'b0;
      block_bad_q <= 1'b0;
      bad_pos_q <= 8'h00;
      bad_holes_q <= 8'h00;
    end else begin
      if (bad_char) begin
        halt_pend_q <= 1'b1;
        block_bad_q <= 1'b1;
        bad_pos_q <= count_q + 8'h01;
        bad_holes_q <= char_holes;
      end else if (char_valid && code_eob) begin
        block_bad_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm latches, only reset clears them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      h_alarm_q <= 1'b0;
      v_alarm_q <= 1'b0;
    end else begin
      if (bad_char) begin
        h_alarm_q <= 1'b1;
      end
      if (odd_block && !any_alarm && !block_bad_q) begin
        v_alarm_q <= 1'b1;
      end
    end
  end

  // indicator shows the number only once the prior block is done
  always_comb begin
    if (state_q != tcp_pkg::tcp_stop_s) begin
      alarm_number = tcp_pkg::alarm_none;
    end else if (h_alarm_q) begin
      alarm_number = tcp_pkg::alarm_horizontal;
    end else if (v_alarm_q) begin
      alarm_number = tcp_pkg::alarm_vertical;
    end else begin
      alarm_number = tcp_pkg::alarm_none;
    end
  end
  assign horizontal_code_alarm = h_alarm_q;
  assign vertical_parity_alarm = v_alarm_q;
  assign alarm_lamp = any_alarm;

  ////////////////////////////////////////////////////////////////////////////
  // block hand-off: clean blocks run, faulty ones are dropped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      exec_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      exec_q <= char_valid && code_eob && !block_bad_q && !bad_char && !any_alarm
                && !odd_block;
      // one pulse per faulty block; nothing read after an alarm is ever run
      discard_q <= (char_valid && code_eob && odd_block && !any_alarm)
                   || bad_char;
    end
  end
  assign block_execute = exec_q;
  assign block_discard = discard_q;

  ////////////////////////////////////////////////////////////////////////////
  // control register, operator vertical check switch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= tcp_pkg::ctrl_reset_value;
    end else if (reg_write && reg_addr == tcp_pkg::tape_ctrl_addr) begin
      ctrl_q <= reg_wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        tcp_pkg::bad_char_position_addr: rdata_q <= {24'h000000, bad_pos_q};
        tcp_pkg::bad_char_holes_addr: rdata_q <= {24'h000000, bad_holes_q};
        tcp_pkg::tape_ctrl_addr: rdata_q <= {24'h000000, ctrl_q};
        tcp_pkg::tape_status_addr: rdata_q <= {20'h00000, state_q, 6'h00,
                                               v_alarm_q, h_alarm_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;
endmodule : tcp_checker
`default_nettype wire

// [tcp_checker_properties.sv]
// Purpose: port-level assertions for the tape checker
// Assumes: one clock domain, async active-low reset
// Notes: control bit shadowed from bus writes
`timescale 1ns/10ps
`default_nettype none
module tcp_checker_props (
  input wire logic clock, // clock
  input wire logic reset_n, // reset
  input wire logic char_valid, // char strobe
  input wire logic [7:0] char_holes, // holes
  input wire logic char_in_zone, // zone
  input wire logic read_enable, // reader go
  input wire logic block_execute, // run pulse
  input wire logic block_discard, // drop pulse
  input wire logic [9:0] alarm_number, // indicator
  input wire logic horizontal_code_alarm, // h alarm
  input wire logic vertical_parity_alarm, // v alarm
  input wire logic alarm_lamp, // lamp
  input wire logic [11:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // wdata
  input wire logic reg_write // write strobe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic bad;
  logic vchk_q;
  // character outside the code table, inside the zone
  assign bad = char_valid && char_in_zone && char_holes != 8'h00 && char_holes != 8'hff
    && char_holes != tcp_pkg::eob_code && !(^char_holes[6:0]);
  // shadow of the vertical check switch
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) vchk_q <= 1'b1;
    else if (reg_write && reg_addr == tcp_pkg::tape_ctrl_addr) vchk_q <= reg_wdata[0];
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_bad; bad && !alarm_lamp |=> horizontal_code_alarm && block_discard; endproperty
  a_bad: assert property (p_bad) else $error("bad char not flagged");
  property p_hhold; horizontal_code_alarm |=> horizontal_code_alarm; endproperty
  a_hhold: assert property (p_hhold) else $error("h alarm dropped");
  property p_vhold; !$fell(vertical_parity_alarm); endproperty
  a_vhold: assert property (p_vhold) else $error("v alarm dropped");
  property p_numh; alarm_number == tcp_pkg::alarm_horizontal |-> horizontal_code_alarm; endproperty
  a_numh: assert property (p_numh) else $error("001 without h alarm");
  property p_numv; alarm_number == tcp_pkg::alarm_vertical |-> vertical_parity_alarm; endproperty
  a_numv: assert property (p_numv) else $error("002 without v alarm");
  property p_noex; alarm_lamp |-> !block_execute; endproperty
  a_noex: assert property (p_noex) else $error("execute after alarm");
  property p_halt; horizontal_code_alarm && char_valid |=> !read_enable; endproperty
  a_halt: assert property (p_halt) else $error("reading not halted");
  property p_voff; !$past(vchk_q) |-> !$rose(vertical_parity_alarm); endproperty
  a_voff: assert property (p_voff) else $error("v alarm while off");
  c_h: cover property ($rose(horizontal_code_alarm));
  c_v: cover property ($rose(vertical_parity_alarm));
  c_ex: cover property (block_execute);
endmodule : tcp_checker_props
bind tcp_checker tcp_checker_props prop_u (.clock, .reset_n, .char_valid, .char_holes,
  .char_in_zone, .read_enable, .block_execute, .block_discard, .alarm_number,
  .horizontal_code_alarm, .vertical_parity_alarm, .alarm_lamp, .reg_addr, .reg_wdata,
  .reg_write);
`default_nettype wire

// [tcp_code_table.sv]
// Purpose: decides whether a tape character is in the valid code table
// Assumes: odd-parity code in channel five, channel eight marks end of block
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module tcp_code_table (
  input wire logic [7:0] holes, // hole pattern, bit n is channel n+1
  input wire logic in_zone, // character lies in significant information zone
  output logic valid, // character is a member of the code table
  output logic is_eob // character is the end-of-block code
);
  // blank tape, delete and end-of-block codes are always accepted; other in-zone codes need odd parity
  always_comb begin
    is_eob = (holes == tcp_pkg::eob_code);
    if (!in_zone) begin
      valid = 1'b1; // outside the zone nothing is checked
    end else if (is_eob || holes == 8'h00 || holes == 8'hff) begin
      valid = 1'b1;
    end else begin
      valid = ^holes[6:0];
    end
  end
endmodule : tcp_code_table
`default_nettype wire

// [tcp_pkg.sv]
// Purpose: constants shared by the tape code and parity checker
// Assumes: 8-bit tape characters, one per strobe
// Notes: register offsets are indices, byte address is four times index
package tcp_pkg;
  localparam logic [9:0] bad_char_position_idx = 10'h2c6; // position register index
  localparam logic [9:0] bad_char_holes_idx = 10'h2c7; // hole pattern register index
  localparam logic [9:0] tape_ctrl_idx = 10'h2c8; // control register index
  localparam logic [9:0] tape_status_idx = 10'h2c9; // status register index
  localparam logic [11:0] bad_char_position_addr = 12'hb18; // byte address of position
  localparam logic [11:0] bad_char_holes_addr = 12'hb1c; // byte address of holes
  localparam logic [11:0] tape_ctrl_addr = 12'hb20; // byte address of control
  localparam logic [11:0] tape_status_addr = 12'hb24; // byte address of status
  localparam int ctrl_vcheck_bit = 0; // vertical check enable field
  localparam logic [7:0] ctrl_reset_value = 8'h01; // vertical check on after reset
  localparam logic [9:0] alarm_none = 10'h000; // no alarm shown
  localparam logic [9:0] alarm_horizontal = 10'h001; // horizontal code alarm number
  localparam logic [9:0] alarm_vertical = 10'h002; // vertical parity alarm number
  localparam logic [7:0] eob_code = 8'h80; // end-of-block code, channel eight only
  localparam logic [7:0] count_reset_value = 8'h00; // position counter after reset
  // states of the block sequencer, one-hot
  typedef enum logic [3:0] {
    tcp_idle_s = 4'h1,
    tcp_read_s = 4'h2,
    tcp_drain_s = 4'h4,
    tcp_stop_s = 4'h8
  } tcp_state_t;
endpackage : tcp_pkg

// [tcp_tape_reader.sv]
// Purpose: behavioural tape reader feeding characters
// Assumes: queue entries are {out_of_zone, holes}
// Notes: advances only while read_enable is high
`timescale 1ns/10ps
`default_nettype none
module tcp_tape_reader (
  input wire logic clock, // clock
  input wire logic reset_n, // reset
  input wire logic read_enable, // may advance
  output logic char_valid, // char strobe
  output logic [7:0] char_holes, // holes
  output logic char_in_zone // zone
);
  logic [8:0] q[$];
  logic [8:0] e;
  initial begin
    char_valid = 1'b0;
    char_holes = 8'h00;
    char_in_zone = 1'b0;
  end
  // idle lines toggle so stale data never looks valid
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) char_valid <= 1'b0;
    else if (read_enable && q.size() > 0) begin
      e = q.pop_front();
      char_valid <= 1'b1;
      char_holes <= e[7:0];
      char_in_zone <= !e[8];
    end else begin
      char_valid <= 1'b0;
      char_holes <= ~char_holes;
      char_in_zone <= ~char_in_zone;
    end
  end
endmodule : tcp_tape_reader
`default_nettype wire

// [test_tape_code_parity_checker.sv]
// Purpose: self-checking bench for the tape checker
// Assumes: reader model drives the tape side
// Notes: expected results come from a queue model
`timescale 1ns/10ps
`default_nettype none
module test_tape_code_parity_checker;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic block_busy = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic char_valid, char_in_zone, read_enable, block_execute, block_discard;
  logic horizontal_code_alarm, vertical_parity_alarm, alarm_lamp;
  logic [7:0] char_holes;
  logic [9:0] alarm_number;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
  int failures = 0, checks = 0, n_exec, n_disc, cyc = 0, seed = 32'h1b1a;
  int e_alarm, e_pos, e_exec, e_holes, e_left;
  logic [8:0] seq[$];
  tcp_checker dut_u (.clock, .reset_n, .char_valid, .char_holes, .char_in_zone,
    .read_enable, .block_busy, .block_execute, .block_discard, .alarm_number,
    .horizontal_code_alarm, .vertical_parity_alarm, .alarm_lamp, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata);
  tcp_tape_reader rdr_u (.clock, .reset_n, .read_enable, .char_valid, .char_holes,
    .char_in_zone);
  ////////////////////////////////////////////////////////////////////////////
  always #10 clock = ~clock;
  // pulse counters and hang guard
  always @(posedge clock) begin
    cyc++;
    if (block_execute === 1'b1) n_exec++;
    if (block_discard === 1'b1) n_disc++;
    if (cyc == 8000) begin
      failures++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // in-zone character with odd parity over channels one to seven
  function automatic logic [8:0] good();
    logic [31:0] r;
    r = $random(seed);
    return {2'b00, ~^r[5:0], r[5:0]};
  endfunction : good
  // reference model: stops at the first alarm, count includes the end code
  task automatic predict(input bit vchk);
    int cnt;
    logic [7:0] h;
    cnt = 0;
    e_alarm = 0;
    e_exec = 0;
    e_left = 0;
    foreach (seq[i]) if (e_alarm == 0) begin
      h = seq[i][7:0];
      cnt++;
      if (!seq[i][8] && h != 8'h00 && h != 8'hff && h != 8'h80 && !(^h[6:0])) begin
        e_alarm = 1;
        e_pos = cnt;
        e_holes = h;
      end else if (h == 8'h80) begin
        if (vchk && cnt % 2) e_alarm = 2;
        else e_exec++;
        cnt = 0;
      end
      // tape stops with one character past the fault read
      if (e_alarm != 0) e_left = (seq.size() - i > 2) ? seq.size() - i - 2 : 0;
    end
  endtask : predict
  task automatic run(input string nm, input bit vchk);
    reset_n <= 1'b0;
    block_busy <= 1'b0;
    rdr_u.q.delete();
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    n_exec = 0;
    n_disc = 0;
    rd(tcp_pkg::tape_ctrl_addr, rd_q);
    chk(rd_q, 32'h1, "ctrl reset value");
    if (!vchk) wr(tcp_pkg::tape_ctrl_addr, 32'h0);
    predict(vchk);
    block_busy <= 1'b1;
    foreach (seq[i]) rdr_u.q.push_back(seq[i]);
    for (int k = 0; k < 300 && rdr_u.q.size() > 0 && alarm_lamp !== 1'b1; k++)
      @(posedge clock);
    repeat (3) @(posedge clock);
    if (e_alarm != 0) chk({22'h0, alarm_number}, 0, "shown before drain");
    block_busy <= 1'b0;
    repeat (3) @(posedge clock);
    chk({22'h0, alarm_number}, e_alarm, "alarm number");
    chk({31'h0, alarm_lamp}, e_alarm != 0, "alarm lamp");
    chk(n_exec, e_exec, "executed blocks");
    chk(n_disc, e_alarm != 0, "discarded blocks");
    if (e_alarm != 0) chk({31'h0, read_enable}, 0, "reading halted");
    chk(rdr_u.q.size(), e_left, "tape stop point");
    chk({30'h0, vertical_parity_alarm, horizontal_code_alarm}, e_alarm, "alarm kind");
    if (e_alarm == 1) begin
      rd(tcp_pkg::bad_char_position_addr, rd_q);
      chk(rd_q, e_pos, "bad position");
      rd(tcp_pkg::bad_char_holes_addr, rd_q);
      chk(rd_q, e_holes, "bad holes");
    end
    rd(12'hb28, rd_q);
    chk(rd_q, 32'h0, "unmapped read");
    $display("test %s done", nm);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seq = {good(), good(), good(), 9'h080};
    seq = {seq, seq};
    run("clean", 1'b1);
    seq = {seq[0:3], good(), good(), 9'h003, good()};
    run("horizontal", 1'b1);
    seq = {good(), good(), 9'h080};
    run("vertical", 1'b1);
    seq = {good(), 9'h105, 9'h080};
    run("unchecked", 1'b0);
    // random block lengths, switch alternating
    for (int t = 0; t < 4; t++) begin
      seq.delete();
      repeat (3) begin
        repeat ($unsigned($random(seed)) % 4) seq.push_back(good());
        seq.push_back(9'h080);
      end
      run("random", t[0]);
    end
    summarize();
  end
endmodule : test_tape_code_parity_checker
`default_nettype wire
